// ===== src/fcoc_top.sv
/*
 Command option configuration register pair with its serial command
 front end, erase blank-check sequencer and reset handling.
 Assumes a serial host in clock mode 0, a fuse array that presents its
 stored byte at power-up, and an erase engine that answers the status
 query in the same cycle and runs the blank scan on request.
*/
module fcoc_top (
	// Clock and reset
	input  wire logic                     sys_clk,
	input  wire logic                     resetn,
	// Serial link pins and hardware reset pin
	input  wire logic                     sckPin,
	input  wire logic                     csPinN,
	input  wire logic                     siPin,
	output logic                          soPin,
	output logic                          soOe,
	input  wire logic                     hwResetPinN,
	// Fuse array
	input  wire logic [7:0]               otpCells,
	output logic                          otpProgram,
	output logic [7:0]                    otpProgData,
	// Live configuration
	input  wire logic                     paramAtTop,
	output fcoc_pkg::fcoc_config_t        liveCfg,
	output logic [8:0]                    pageWrapMask,
	// Erase engine handshake
	input  wire logic                     sectorEraseOk,
	input  wire logic                     scanZeroFound,
	input  wire logic                     scanDone,
	output logic                          statusQuery,
	output logic                          blankScanReq,
	output fcoc_pkg::fcoc_erase_req_t     eraseReq,
	output logic                          eraseStart,
	output logic                          eraseSkip,
	// Command strobes
	output logic                          resumeCmd,
	output logic                          clearStatusCmd,
	output logic                          softReset
);
	fcoc_pkg::fcoc_state_t     st;
	fcoc_pkg::fcoc_state_t     nx;
	fcoc_pkg::fcoc_erase_req_t issueReq;
	logic                      frameEnd;
	logic                      eraseIssue;
	logic                      inParam;
	logic [7:0]                byteIn;
	logic [23:0]               rdAddr;

	// Level counts only once the second and third stages agree
	function automatic logic filt(input logic [2:0] s, input logic old);
		filt = (s[1] == s[2]) ? s[1] : old;
	endfunction

	assign inParam = (st.addr[23:15] == (paramAtTop ? fcoc_pkg::PARAM_TOP
		: fcoc_pkg::PARAM_BOT));

	always_comb begin
		nx = st;
		frameEnd = 1'b0;
		eraseIssue = 1'b0;
		issueReq = st.erReq;
		rdAddr = st.addr;
		nx.eraseStart = 1'b0;
		nx.eraseSkip = 1'b0;
		nx.resumeCmd = 1'b0;
		nx.clearStatusCmd = 1'b0;
		nx.softRst = 1'b0;
		nx.otpProgram = 1'b0;
		nx.sckSync = {st.sckSync[1:0], sckPin};
		nx.csnSync = {st.csnSync[1:0], csPinN};
		nx.siSync = {st.siSync[1:0], siPin};
		nx.hwRstSync = {st.hwRstSync[1:0], hwResetPinN};
		nx.sckLvl = filt(st.sckSync, st.sckLvl);
		nx.csnLvl = filt(st.csnSync, st.csnLvl);
		nx.siLvl = filt(st.siSync, st.siLvl);
		nx.hwRstNLvl = filt(st.hwRstSync, st.hwRstNLvl);
		byteIn = {st.shift[6:0], nx.siLvl};
		// Fuses are caught after release, never under the async reset
		if (!st.booted) begin
			nx.booted = 1'b1;
			nx.nv = otpCells & fcoc_pkg::NV_WR_MASK;
			nx.vol = otpCells & fcoc_pkg::VOL_WR_MASK;
		end
		if (nx.csnLvl) begin
			frameEnd = !st.csnLvl;
			nx.bitCnt = 3'h0;
			nx.byteCnt = 3'h0;
			nx.txArm = 1'b0;
			nx.soEn = 1'b0;
			nx.wdataOk = 1'b0;
		end else if (nx.sckLvl && !st.sckLvl) begin
			nx.shift = byteIn;
			nx.bitCnt = st.bitCnt + 3'h1;
			if (st.bitCnt == 3'h7) begin
				case (st.byteCnt)
					3'h0: nx.opcode = byteIn;
					3'h1, 3'h2, 3'h3: nx.addr = {st.addr[15:0], byteIn};
					default: begin
						if (!st.wdataOk) begin
							nx.wdata = byteIn;
							nx.wdataOk = 1'b1;
						end
					end
				endcase
				if (st.byteCnt != fcoc_pkg::BYTES_FULL)
					nx.byteCnt = st.byteCnt + 3'h1;
				if (st.byteCnt == fcoc_pkg::ADDR_LAST &&
				    st.opcode == fcoc_pkg::OP_READ_ANY) begin
					rdAddr = {st.addr[15:0], byteIn};
					nx.txArm = 1'b1;
					if (rdAddr == fcoc_pkg::ADDR_NV)
						nx.txShift = st.nv;
					else if (rdAddr == fcoc_pkg::ADDR_VOL)
						nx.txShift = st.vol | (st.nv & fcoc_pkg::UNIFORM_MASK);
					else
						nx.txShift = 8'h00;
				end
			end
		end else if (!nx.sckLvl && st.sckLvl && st.txArm) begin
			// Rotating repeats the byte for as long as the host clocks
			nx.soOut = st.txShift[7];
			nx.txShift = {st.txShift[6:0], st.txShift[7]};
			nx.soEn = 1'b1;
		end
		// Commands act only on a whole-byte frame at deselect
		if (frameEnd && st.bitCnt == 3'h0) begin
			nx.rstArmed = 1'b0;
			case (st.opcode)
				fcoc_pkg::OP_WRITE_ANY: begin
					if (st.wdataOk && st.addr == fcoc_pkg::ADDR_NV) begin
						nx.nv = st.nv | (st.wdata & fcoc_pkg::NV_WR_MASK);
						nx.otpProgram = 1'b1;
					end else if (st.wdataOk && st.addr == fcoc_pkg::ADDR_VOL)
						nx.vol = st.wdata & fcoc_pkg::VOL_WR_MASK;
				end
				fcoc_pkg::OP_RESUME_CLR: begin
					if (st.byteCnt == fcoc_pkg::ONE_BYTE) begin
						nx.resumeCmd = st.vol[fcoc_pkg::BIT_RESUME];
						nx.clearStatusCmd = !st.vol[fcoc_pkg::BIT_RESUME];
					end
				end
				fcoc_pkg::OP_LEGACY_RST: begin
					nx.softRst = st.byteCnt == fcoc_pkg::ONE_BYTE &&
						st.vol[fcoc_pkg::BIT_LEGACY];
				end
				fcoc_pkg::OP_RST_EN:
					nx.rstArmed = st.byteCnt == fcoc_pkg::ONE_BYTE;
				fcoc_pkg::OP_RST: begin
					nx.softRst = st.byteCnt == fcoc_pkg::ONE_BYTE &&
						st.rstArmed;
				end
				fcoc_pkg::OP_ERASE_4K: begin
					// Hybrid map only, and only inside the overlay
					eraseIssue = st.byteCnt == fcoc_pkg::BYTES_FULL &&
						!st.nv[fcoc_pkg::BIT_UNIFORM] && inParam;
					issueReq = '{st.addr & fcoc_pkg::MASK_4K,
						fcoc_pkg::SIZE_4K};
				end
				fcoc_pkg::OP_ERASE_BLK, fcoc_pkg::OP_ERASE_BLK4: begin
					eraseIssue = st.byteCnt == fcoc_pkg::BYTES_FULL;
					if (st.vol[fcoc_pkg::BIT_BLKSZ])
						issueReq = '{st.addr & fcoc_pkg::MASK_256K,
							fcoc_pkg::SIZE_256K};
					else
						issueReq = '{st.addr & fcoc_pkg::MASK_64K,
							fcoc_pkg::SIZE_64K};
				end
				fcoc_pkg::OP_ERASE_CHIP, fcoc_pkg::OP_ERASE_ALL: begin
					eraseIssue = st.byteCnt == fcoc_pkg::ONE_BYTE;
					issueReq = '{24'h00_0000, fcoc_pkg::SIZE_CHIP};
				end
				default: ;
			endcase
		end
		case (st.erState)
			fcoc_pkg::ER_STATUS: begin
				if (!sectorEraseOk) begin
					nx.eraseStart = 1'b1;
					nx.erState = fcoc_pkg::ER_IDLE;
				end else
					nx.erState = fcoc_pkg::ER_SCAN;
			end
			fcoc_pkg::ER_SCAN: begin
				if (scanZeroFound) begin
					nx.eraseStart = 1'b1;
					nx.erState = fcoc_pkg::ER_IDLE;
				end else if (scanDone) begin
					nx.eraseSkip = 1'b1;
					nx.erState = fcoc_pkg::ER_IDLE;
				end
			end
			default: ;
		endcase
		// A new erase while one is being evaluated is dropped
		if (eraseIssue && st.erState == fcoc_pkg::ER_IDLE) begin
			nx.erReq = issueReq;
			if (st.vol[fcoc_pkg::BIT_BLANK])
				nx.erState = fcoc_pkg::ER_STATUS;
			else
				nx.eraseStart = 1'b1;
		end
		if (st.softRst || !nx.hwRstNLvl) begin
			nx.vol = st.nv & fcoc_pkg::VOL_WR_MASK;
			nx.erState = fcoc_pkg::ER_IDLE;
			nx.rstArmed = 1'b0;
		end
		nx.pageMask = nx.vol[fcoc_pkg::BIT_WRAP] ? fcoc_pkg::WRAP_512
			: fcoc_pkg::WRAP_256;
	end

	always_ff @(posedge sys_clk or negedge resetn) begin
		if (!resetn) begin
			st <= '0;
			st.csnSync <= fcoc_pkg::SYNC_IDLE;
			st.hwRstSync <= fcoc_pkg::SYNC_IDLE;
			st.csnLvl <= 1'b1;
			st.hwRstNLvl <= 1'b1;
			st.nv <= fcoc_pkg::NV_FACTORY;
			st.pageMask <= fcoc_pkg::WRAP_256;
		end else
			st <= nx;
	end

	assign soPin = st.soOut;
	assign soOe = st.soEn;
	assign otpProgram = st.otpProgram;
	assign otpProgData = st.nv;
	assign liveCfg = {st.vol[5:4], st.nv[fcoc_pkg::BIT_UNIFORM],
		st.vol[2:0]};
	assign pageWrapMask = st.pageMask;
	assign statusQuery = st.erState == fcoc_pkg::ER_STATUS;
	assign blankScanReq = st.erState == fcoc_pkg::ER_SCAN;
	assign eraseReq = st.erReq;
	assign eraseStart = st.eraseStart;
	assign eraseSkip = st.eraseSkip;
	assign resumeCmd = st.resumeCmd;
	assign clearStatusCmd = st.clearStatusCmd;
	assign softReset = st.softRst;

	default clocking cb @(posedge sys_clk); endclocking
	default disable iff (!resetn);

	sequence s_cmd(logic [7:0] op, logic [2:0] n);
		frameEnd && st.opcode == op && st.byteCnt == n && st.bitCnt == 3'h0;
	endsequence
	sequence s_scan_hit;
		st.erState == fcoc_pkg::ER_SCAN && scanZeroFound;
	endsequence

	AST_OTP_ONEWAY: assert property (st.booted |=>
		(st.nv & $past(st.nv)) == $past(st.nv))
		else $error("stored bit returned to zero");
	AST_RSVD_ZERO: assert property (st.booted |->
		st.nv[7:6] == 2'b00 && st.vol[7:6] == 2'b00)
		else $error("reserved bit set");
	AST_SOFT_RELOAD: assert property (st.softRst |=>
		st.vol == ($past(st.nv) & fcoc_pkg::VOL_WR_MASK))
		else $error("working copy not reloaded");
	AST_UNIFORM_RO: assert property (s_cmd(fcoc_pkg::OP_WRITE_ANY,
		fcoc_pkg::BYTES_FULL) ##0 st.addr == fcoc_pkg::ADDR_VOL |=>
		liveCfg.uniformMap == $past(st.nv[3]) && !st.vol[3])
		else $error("uniform bit changed by write");
	AST_BLANK_OFF: assert property (eraseIssue &&
		st.erState == fcoc_pkg::ER_IDLE && !st.vol[fcoc_pkg::BIT_BLANK]
		|=> st.eraseStart && st.erReq == $past(issueReq))
		else $error("erase not started directly");
	AST_BLANK_ON: assert property (eraseIssue && nx.hwRstNLvl &&
		!st.softRst && st.erState == fcoc_pkg::ER_IDLE &&
		st.vol[fcoc_pkg::BIT_BLANK] |=> !st.eraseStart && statusQuery)
		else $error("blank check skipped");
	AST_STATUS_BAD: assert property (statusQuery &&
		!sectorEraseOk |=> st.eraseStart && !blankScanReq)
		else $error("failed sector not erased");
	AST_SCAN_ZERO: assert property (s_scan_hit |=>
		st.eraseStart ##1 !st.eraseStart)
		else $error("zero found but no erase");
	AST_SCAN_BLANK: assert property (blankScanReq && !scanZeroFound &&
		scanDone |=> st.eraseSkip && !st.eraseStart)
		else $error("blank sector not skipped");
	AST_PAGE_WRAP: assert property (st.booted |->
		pageWrapMask == (st.vol[4] ? fcoc_pkg::WRAP_512 : fcoc_pkg::WRAP_256))
		else $error("page wrap mask wrong");
	AST_PARAM_GATE: assert property (s_cmd(fcoc_pkg::OP_ERASE_4K,
		fcoc_pkg::BYTES_FULL) ##0 (st.nv[3] || !inParam) ##0
		st.erState == fcoc_pkg::ER_IDLE |=> !st.eraseStart && !statusQuery)
		else $error("4KB erase outside hybrid overlay");
	AST_RESUME: assert property (s_cmd(fcoc_pkg::OP_RESUME_CLR,
		fcoc_pkg::ONE_BYTE) |=> st.resumeCmd == $past(st.vol[2]) &&
		st.clearStatusCmd != st.resumeCmd)
		else $error("30h decoded wrongly");
	AST_BLOCK_SIZE: assert property (s_cmd(fcoc_pkg::OP_ERASE_BLK,
		fcoc_pkg::BYTES_FULL) ##0 st.erState == fcoc_pkg::ER_IDLE |=>
		st.erReq.size == ($past(st.vol[1]) ? fcoc_pkg::SIZE_256K
		: fcoc_pkg::SIZE_64K))
		else $error("block erase size wrong");
	AST_LEGACY_OFF: assert property (s_cmd(fcoc_pkg::OP_LEGACY_RST,
		fcoc_pkg::ONE_BYTE) |=> st.softRst == $past(st.vol[0]))
		else $error("F0h reset gating wrong");
	AST_RST_PAIR: assert property (s_cmd(fcoc_pkg::OP_RST,
		fcoc_pkg::ONE_BYTE) ##0 st.rstArmed |=> st.softRst ##1 !st.softRst)
		else $error("66h 99h did not reset");
endmodule

// ===== src/fcoc_pkg.sv
/*
 Constants, field layout and carrier types of the command option
 configuration register pair. Assumes nothing beyond a SystemVerilog tool.
*/
package fcoc_pkg;
	// Serial command opcodes
	localparam logic [7:0] OP_READ_ANY   = 8'h65;
	localparam logic [7:0] OP_WRITE_ANY  = 8'h71;
	localparam logic [7:0] OP_RESUME_CLR = 8'h30;
	localparam logic [7:0] OP_LEGACY_RST = 8'hF0;
	localparam logic [7:0] OP_RST_EN     = 8'h66;
	localparam logic [7:0] OP_RST        = 8'h99;
	localparam logic [7:0] OP_ERASE_4K   = 8'h20;
	localparam logic [7:0] OP_ERASE_BLK  = 8'hD8;
	localparam logic [7:0] OP_ERASE_BLK4 = 8'hDC;
	localparam logic [7:0] OP_ERASE_CHIP = 8'h60;
	localparam logic [7:0] OP_ERASE_ALL  = 8'hC7;
	// Register addresses on the register-access commands
	localparam logic [23:0] ADDR_NV  = 24'h00_0004;
	localparam logic [23:0] ADDR_VOL = 24'h80_0004;
	// Field positions
	localparam int BIT_BLANK   = 5;
	localparam int BIT_WRAP    = 4;
	localparam int BIT_UNIFORM = 3;
	localparam int BIT_RESUME  = 2;
	localparam int BIT_BLKSZ   = 1;
	localparam int BIT_LEGACY  = 0;
	// Values after reset and write masks
	localparam logic [7:0] NV_FACTORY   = 8'h00;
	localparam logic [7:0] NV_WR_MASK   = 8'h3F;
	localparam logic [7:0] VOL_WR_MASK  = 8'h37;
	localparam logic [7:0] UNIFORM_MASK = 8'h08;
	localparam logic [2:0] SYNC_IDLE    = 3'h7;
	// Page buffer wrap masks
	localparam logic [8:0] WRAP_256 = 9'h0FF;
	localparam logic [8:0] WRAP_512 = 9'h1FF;
	// Erase alignment and parameter region
	localparam logic [23:0] MASK_4K   = 24'hFF_F000;
	localparam logic [23:0] MASK_64K  = 24'hFF_0000;
	localparam logic [23:0] MASK_256K = 24'hFC_0000;
	localparam logic [8:0]  PARAM_TOP = 9'h1FF;
	localparam logic [8:0]  PARAM_BOT = 9'h000;
	// Frame byte counts
	localparam logic [2:0] ONE_BYTE   = 3'h1;
	localparam logic [2:0] ADDR_LAST  = 3'h3;
	localparam logic [2:0] BYTES_FULL = 3'h4;

	typedef enum logic [1:0] {
		SIZE_4K, SIZE_64K, SIZE_256K, SIZE_CHIP
	} fcoc_erase_size_t;

	typedef enum logic [1:0] {
		ER_IDLE, ER_STATUS, ER_SCAN
	} fcoc_erase_state_t;

	typedef struct packed {
		logic [23:0]      addr;
		fcoc_erase_size_t size;
	} fcoc_erase_req_t;

	typedef struct packed {
		logic blankCheck;
		logic pageWrap512;
		logic uniformMap;
		logic resumeSelect;
		logic blockErase256;
		logic legacyResetEn;
	} fcoc_config_t;

	typedef struct packed {
		logic [2:0]        sckSync;
		logic [2:0]        csnSync;
		logic [2:0]        siSync;
		logic [2:0]        hwRstSync;
		logic              sckLvl;
		logic              csnLvl;
		logic              siLvl;
		logic              hwRstNLvl;
		logic              booted;
		logic [2:0]        bitCnt;
		logic [2:0]        byteCnt;
		logic [7:0]        shift;
		logic [7:0]        opcode;
		logic [23:0]       addr;
		logic [7:0]        wdata;
		logic              wdataOk;
		logic              txArm;
		logic [7:0]        txShift;
		logic              soOut;
		logic              soEn;
		logic              rstArmed;
		logic [7:0]        nv;
		logic [7:0]        vol;
		logic [8:0]        pageMask;
		fcoc_erase_state_t erState;
		fcoc_erase_req_t   erReq;
		logic              eraseStart;
		logic              eraseSkip;
		logic              resumeCmd;
		logic              clearStatusCmd;
		logic              softRst;
		logic              otpProgram;
	} fcoc_state_t;
endpackage

// ===== dv/fcoc_host_model.sv
/*
 Serial host model: mode 0 frames, MSB first, data out sampled on rise.
 Assumes its pins wired straight to the device's serial link pins.
*/
module fcoc_host_model (
	// Serial pins
	output logic      sck,
	output logic      csN,
	output logic      si,
	input  wire logic so
);
	timeunit 1ns;
	timeprecision 100ps;

	initial begin
		sck = 1'b0;
		csN = 1'b1;
		si  = 1'b0;
	end

	// Clock stands low outside frames; gap covers the deselect filter
	task automatic frame(input int n, input logic [39:0] d,
			output logic [7:0] rd);
		rd = 8'h00;
		csN = 1'b0;
		#62.5;
		for (int i = 8 * n - 1; i >= 0; i--) begin
			si = d[i];
			#62.5;
			sck = 1'b1;
			if (i < 8)
				rd = {rd[6:0], so};
			#62.5;
			sck = 1'b0;
		end
		// Released line must not keep a stale level
		si = ~si;
		#62.5;
		csN = 1'b1;
		#400;
	endtask
endmodule

// ===== dv/testbench.sv
/*
 Self-checking bench of the command option register pair.
 Assumes fcoc_top and the host model; erase engine modelled here.
*/
module testbench;
	timeunit 1ns;
	timeprecision 100ps;
	logic                      sys_clk, resetn, hwResetPinN, paramAtTop;
	logic                      sectorEraseOk, scanZeroFound, scanDone;
	logic [7:0]                otpCells, nv, vol, rd;
	wire logic                 sck, csN, si, soPin, soOe, so;
	wire logic                 otpProgram, statusQuery, blankScanReq;
	wire logic [7:0]           otpProgData;
	wire logic [8:0]           pageWrapMask;
	wire logic                 eraseStart, eraseSkip, resumeCmd;
	wire logic                 clearStatusCmd, softReset;
	wire logic [6:0]           pulses;
	fcoc_pkg::fcoc_config_t    liveCfg;
	fcoc_pkg::fcoc_erase_req_t eraseReq, lastReq;
	int                        miscompares, comparisons, cyc, wcnt;
	int                        pc[7], ep[7];
	bit                        okAns, zeroAns, alt;
	logic [7:0]                ops[8] = '{8'h20, 8'hD8, 8'hDC, 8'h60,
		8'hC7, 8'hD8, 8'h20, 8'hDC};

	assign so = soOe ? soPin : 1'bz;
	assign pulses = {otpProgram, statusQuery, softReset, clearStatusCmd,
		resumeCmd, eraseSkip, eraseStart};

	fcoc_host_model i_host (.sck(sck), .csN(csN), .si(si), .so(so));

	fcoc_top i_dut (.sys_clk(sys_clk), .resetn(resetn), .sckPin(sck),
		.csPinN(csN), .siPin(si), .soPin(soPin), .soOe(soOe),
		.hwResetPinN(hwResetPinN), .otpCells(otpCells),
		.otpProgram(otpProgram), .otpProgData(otpProgData),
		.paramAtTop(paramAtTop), .liveCfg(liveCfg),
		.pageWrapMask(pageWrapMask), .sectorEraseOk(sectorEraseOk),
		.scanZeroFound(scanZeroFound), .scanDone(scanDone),
		.statusQuery(statusQuery), .blankScanReq(blankScanReq),
		.eraseReq(eraseReq), .eraseStart(eraseStart),
		.eraseSkip(eraseSkip), .resumeCmd(resumeCmd),
		.clearStatusCmd(clearStatusCmd), .softReset(softReset));

	initial begin
		sys_clk = 1'b0;
		forever #5 sys_clk = ~sys_clk;
	end

	always @(posedge sys_clk) begin
		cyc++;
		for (int i = 0; i < 7; i++)
			pc[i] += int'(pulses[i] === 1'b1);
		if (eraseStart === 1'b1 || eraseSkip === 1'b1)
			lastReq <= eraseReq;
		if (cyc == 60000) begin
			miscompares++;
			results();
		end
	end

	// Erase engine answers the scan three cycles after the request
	always @(negedge sys_clk) begin
		sectorEraseOk <= okAns;
		scanZeroFound <= 1'b0;
		scanDone <= 1'b0;
		wcnt <= (blankScanReq === 1'b1) ? wcnt + 1 : 0;
		if (blankScanReq === 1'b1 && wcnt == 2) begin
			scanZeroFound <= zeroAns;
			scanDone <= !zeroAns;
		end
	end

	task automatic check(input string nm, input logic [31:0] seen, exp);
		comparisons++;
		if (seen !== exp) begin
			miscompares++;
			$display("wrong value %s expected %h seen %h", nm, exp, seen);
		end
	endtask

	task automatic results;
		$display("comparisons %0d miscompares %0d", comparisons,
			miscompares);
		if (miscompares == 0 && comparisons > 0)
			$display("Regression OK");
		else
			$display("Regression broken");
		$finish;
	endtask

	task automatic tdone(input string s);
		$display("test %s finished", s);
	endtask

	task automatic cmd(input int n, input logic [39:0] d);
		i_host.frame(n, d, rd);
		@(negedge sys_clk);
	endtask

	task automatic chk_pulses;
		for (int i = 0; i < 7; i++)
			check("pulse count", 32'(pc[i]), 32'(ep[i]));
	endtask

	task automatic chk_regs;
		logic [7:0] lv;
		lv = vol | (nv & 8'h08);
		cmd(5, {8'h65, fcoc_pkg::ADDR_NV, 8'h00});
		check("stored copy", 32'(rd), 32'(nv));
		cmd(5, {8'h65, fcoc_pkg::ADDR_VOL, 8'h00});
		check("working copy", 32'(rd), 32'(lv));
		check("liveCfg", 32'(liveCfg), 32'(lv[5:0]));
		check("wrap mask", 32'(pageWrapMask),
			lv[4] ? 32'(9'h1FF) : 32'(9'h0FF));
		check("fuse data", 32'(otpProgData), 32'(nv));
	endtask

	// Bit 3 always written equal to the stored bit
	task automatic wvol(input logic [7:0] w);
		w[3] = nv[3];
		cmd(5, {8'h71, fcoc_pkg::ADDR_VOL, w});
		vol = w & 8'h37;
	endtask

	task automatic erase(input logic [7:0] op);
		logic [23:0] a, ea;
		logic [1:0]  sz;
		bit          ok;
		a = 24'($urandom);
		// Every other 4KB erase aims outside the overlay and must drop
		if (op == 8'h20) begin
			alt = !alt;
			a = {(paramAtTop ^ alt) ? 9'h1FF : 9'h000, a[14:0]};
		end
		okAns = 1'($urandom);
		zeroAns = 1'($urandom);
		ok = !(op == 8'h20 && (nv[3] || alt));
		sz = (op == 8'h20) ? 2'h0 : (op == 8'h60 || op == 8'hC7) ? 2'h3 :
			vol[1] ? 2'h2 : 2'h1;
		ea = (sz == 2'h0) ? a & fcoc_pkg::MASK_4K :
			(sz == 2'h1) ? a & fcoc_pkg::MASK_64K :
			(sz == 2'h2) ? a & fcoc_pkg::MASK_256K : 24'h00_0000;
		if (sz == 2'h3)
			cmd(1, 40'(op));
		else
			cmd(4, 40'({op, a}));
		if (ok && !vol[5])
			ep[0]++;
		if (ok && vol[5]) begin
			ep[5]++;
			ep[(okAns && !zeroAns) ? 1 : 0]++;
		end
		chk_pulses;
		if (ok)
			check("erase request", 32'(lastReq), 32'({ea, sz}));
	endtask

	initial begin
		logic [7:0] w;
		void'($urandom(23820));
		resetn = 1'b0;
		hwResetPinN = 1'b1;
		paramAtTop = 1'b0;
		sectorEraseOk = 1'b0;
		scanZeroFound = 1'b0;
		scanDone = 1'b0;
		otpCells = 8'($urandom);
		nv = otpCells & 8'h3F;
		vol = nv & 8'h37;
		repeat (5) @(negedge sys_clk);
		resetn = 1'b1;
		repeat (5) @(negedge sys_clk);
		chk_regs;
		tdone("power-on load");
		for (int k = 0; k < 8; k++) begin
			w = 8'($urandom);
			w[5] = k[0];
			w[2] = k[1];
			w[0] = k[2];
			wvol(w);
			paramAtTop = 1'($urandom);
			chk_regs;
			erase(ops[k]);
			cmd(1, 40'(8'h30));
			ep[vol[2] ? 2 : 3]++;
			cmd(1, 40'(8'hF0));
			if (vol[0]) begin
				ep[4]++;
				vol = nv & 8'h37;
			end
			chk_pulses;
			chk_regs;
			tdone("working copy");
		end
		w = 8'($urandom) | 8'h08;
		cmd(5, {8'h71, fcoc_pkg::ADDR_NV, w});
		nv = nv | (w & 8'h3F);
		ep[6]++;
		chk_regs;
		cmd(5, {8'h71, fcoc_pkg::ADDR_NV, 8'h00});
		ep[6]++;
		chk_regs;
		erase(8'h20);
		tdone("stored copy");
		wvol(~nv);
		cmd(1, 40'(8'h66));
		cmd(1, 40'(8'h30));
		cmd(1, 40'(8'h99));
		ep[vol[2] ? 2 : 3]++;
		cmd(1, 40'(8'h66));
		cmd(1, 40'(8'h99));
		ep[4]++;
		vol = nv & 8'h37;
		chk_pulses;
		chk_regs;
		tdone("software reset");
		wvol(~nv);
		hwResetPinN = 1'b0;
		repeat (10) @(negedge sys_clk);
		hwResetPinN = 1'b1;
		repeat (10) @(negedge sys_clk);
		vol = nv & 8'h37;
		chk_regs;
		tdone("hardware reset");
		results();
	end
endmodule
